// file: rtl/timer_output_reload_pkg.sv
// package: register map, field layout and reset values of the timer output and reload control block
//
// Behaviour
// - output-source bit zero gives software the pin; one hands it to timer logic.
// - output-level bits read back the pin level and set it when written.
// - output-level writes only land on channels under software control.
// - mode, config, reload-enable and reload-timing writes only land on stopped channels.
// - under timer control, mode bit zero is independent, one is synchronous output.
// - config bit zero selects toggle operation; one has no function.
// - polarity zero is active high, one is active low.
// - polarity applies in timer modes only, never in software direct mode.
// - reload-enable one updates compare data at the rewrite trigger.
// - for PWM functions reload-enable also reloads polarity with the data.
// - reload-timing zero fires the trigger at master counter start; one no function.
// - writing one to an arm bit sets the pending flag; arm self-clears.
// - the arm register is write-only and reads zero.
// - the status register reports per-channel pending rewrite.
// - counter-enabled bit set by start trigger or input, cleared by stop.
// - stopping a counter holds counter value, level bit and pin.
package timer_output_reload_pkg;

  localparam int unsigned CHANNELS  = 4;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned CDR_W     = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OUTPUT_LEVEL_OFFSET   = 8'h5C;
  localparam logic [7:0] OUTPUT_SOURCE_OFFSET  = 8'h60;
  localparam logic [7:0] OUTPUT_POLARITY_OFFSET = 8'h64;
  localparam logic [7:0] RELOAD_ARM_OFFSET     = 8'h68;
  localparam logic [7:0] RELOAD_STATUS_OFFSET  = 8'h6C;
  localparam logic [7:0] OUTPUT_MODE_OFFSET    = 8'h98;
  localparam logic [7:0] OUTPUT_CONFIG_OFFSET  = 8'h9C;
  localparam logic [7:0] RELOAD_ENABLE_OFFSET  = 8'hA0;
  localparam logic [7:0] RELOAD_TIMING_OFFSET  = 8'hA4;
  // chosen: counter enable status and start/stop triggers, compare staging
  localparam logic [7:0] COUNTER_STATUS_OFFSET = 8'h50;
  localparam logic [7:0] COUNTER_START_OFFSET  = 8'h54;
  localparam logic [7:0] COUNTER_STOP_OFFSET   = 8'h58;
  localparam logic [7:0] PWM_FUNC_OFFSET       = 8'hB0;
  localparam logic [7:0] COMPARE_STAGE_OFFSET  = 8'hC0; // plus 4 per channel
  localparam logic [7:0] COMPARE_ACTIVE_OFFSET = 8'hD0; // plus 4 per channel

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SOURCE_RESET   = 4'h0;
  localparam logic [3:0] LEVEL_RESET    = 4'h0;
  localparam logic [3:0] POLARITY_RESET = 4'h0;
  localparam logic [3:0] MODE_RESET     = 4'h0;
  localparam logic [3:0] CONFIG_RESET   = 4'h0;
  localparam logic [3:0] ENABLE_RESET   = 4'h0;
  localparam logic [3:0] TIMING_RESET   = 4'h0;
  localparam logic [3:0] PENDING_RESET  = 4'h0;

  // per-channel controls presented to the timer core
  typedef struct packed {
    logic [3:0] timer_mode_sync;
    logic [3:0] toggle_mode;
    logic [3:0] counter_enabled;
  } channel_ctrl_t;

  // apb request bundle
  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata;
  } apb_req_t;

endpackage

// file: rtl/timer_output_reload_ctrl.sv
// module: output control and synchronous rewrite control of a four-channel timer array unit
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module timer_output_reload_ctrl
  import timer_output_reload_pkg::*;
(
  input  wire logic                                  clock_i,
  input  wire logic                                  rstn_i,
  input  wire logic                                  clk_en_i,
  input  wire timer_output_reload_pkg::apb_req_t      apb_req_i,
  output logic [timer_output_reload_pkg::DATA_W-1:0] prdata_o,
  output logic                                       pready_o,
  output logic                                       pslverr_o,
  input  wire logic [3:0]                            start_input_i,
  input  wire logic [3:0]                            master_start_i,
  input  wire logic [3:0]                            timer_level_i,
  output logic [3:0]                                 channel_output_pin_o,
  output timer_output_reload_pkg::channel_ctrl_t     channel_ctrl_o,
  output logic [3:0]                                 reload_done_o,
  output logic [4*timer_output_reload_pkg::CDR_W-1:0] compare_data_o
);
  import timer_output_reload_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [3:0]       output_source_select;
  logic [3:0]       channel_output_level;
  logic [3:0]       output_polarity;
  logic [3:0]       polarity_active;
  logic [3:0]       output_mode_select;
  logic [3:0]       output_config;
  logic [3:0]       reload_enable;
  logic [3:0]       reload_timing_select;
  logic [3:0]       reload_pending_status;
  logic [3:0]       counter_enabled_status;
  logic [3:0]       pwm_function;
  logic [CDR_W-1:0] compare_stage [CHANNELS];
  logic [CDR_W-1:0] compare_data_register [CHANNELS];

  logic             wr_access;
  logic             rd_access;
  logic [3:0]       wdata4;
  logic [3:0]       rewrite_trigger;
  logic [3:0]       next_level;
  logic [DATA_W-1:0] next_rdata;
  logic             next_err;

  // register offset compare for the current address
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // hit on one channel's word of a per-channel window, exact compare against base plus 4 per channel
  function automatic logic chan_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] base,
                                    input int unsigned ch);
    return addr == (base + 8'(ch * 4));
  endfunction

  // writes land only at the edge that shows pready; a request held past that edge lands again two cycles later
  assign wr_access = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & pready_o & clk_en_i;
  assign rd_access = apb_req_i.psel & apb_req_i.penable & ~apb_req_i.pwrite & clk_en_i;
  assign wdata4    = apb_req_i.pwdata[3:0];

  // trigger fires at master counter start; timing value one never fires
  assign rewrite_trigger = master_start_i & ~reload_timing_select & reload_enable;

  // ----------------------------------------------------------------
  // counter enable status
  // ----------------------------------------------------------------
  // stop wins over start in the same cycle; only the enable bit changes,
  // so the held level and pin are untouched by a stop
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      counter_enabled_status <= 4'h0;
    end else if (clk_en_i) begin
      counter_enabled_status <= (counter_enabled_status | start_input_i
                                 | ((wr_access && hit(apb_req_i.paddr, COUNTER_START_OFFSET)) ? wdata4 : 4'h0))
                                & ~((wr_access && hit(apb_req_i.paddr, COUNTER_STOP_OFFSET)) ? wdata4 : 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // output source select
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      output_source_select <= SOURCE_RESET;
    end else if (clk_en_i && wr_access && hit(apb_req_i.paddr, OUTPUT_SOURCE_OFFSET)) begin
      output_source_select <= wdata4;
    end
  end

  // ----------------------------------------------------------------
  // output level: software bits writable only under direct control,
  // timer-controlled bits follow the timer level through the applied polarity, only while their counter is enabled
  // ----------------------------------------------------------------
  always_comb begin
    next_level = channel_output_level;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (output_source_select[ch]) begin
        if (counter_enabled_status[ch]) begin
          next_level[ch] = timer_level_i[ch] ^ polarity_active[ch];
        end
      end else if (wr_access && hit(apb_req_i.paddr, OUTPUT_LEVEL_OFFSET)) begin
        next_level[ch] = wdata4[ch];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      channel_output_level <= LEVEL_RESET;
    end else if (clk_en_i) begin
      channel_output_level <= next_level;
    end
  end

  // pin registered from the same next level as the level register, in either source mode
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      channel_output_pin_o <= LEVEL_RESET;
    end else if (clk_en_i) begin
      channel_output_pin_o <= next_level;
    end
  end

  // ----------------------------------------------------------------
  // polarity: written value staged; applied copy reloads at trigger
  // for pwm functions with reload enabled
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      output_polarity <= POLARITY_RESET;
    end else if (clk_en_i && wr_access && hit(apb_req_i.paddr, OUTPUT_POLARITY_OFFSET)) begin
      output_polarity <= wdata4;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      polarity_active <= POLARITY_RESET;
    end else if (clk_en_i) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (pwm_function[ch] && reload_enable[ch]) begin
          if (rewrite_trigger[ch] && reload_pending_status[ch]) begin
            polarity_active[ch] <= output_polarity[ch];
          end
        end else begin
          polarity_active[ch] <= output_polarity[ch];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // stop-guarded configuration registers
  // ----------------------------------------------------------------
  // a bit only lands where its counter is stopped
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      output_mode_select   <= MODE_RESET;
      output_config        <= CONFIG_RESET;
      reload_enable        <= ENABLE_RESET;
      reload_timing_select <= TIMING_RESET;
      pwm_function         <= 4'h0;
    end else if (clk_en_i && wr_access) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (!counter_enabled_status[ch]) begin
          if (hit(apb_req_i.paddr, OUTPUT_MODE_OFFSET)) output_mode_select[ch] <= wdata4[ch];
          if (hit(apb_req_i.paddr, OUTPUT_CONFIG_OFFSET)) output_config[ch] <= wdata4[ch];
          if (hit(apb_req_i.paddr, RELOAD_ENABLE_OFFSET)) reload_enable[ch] <= wdata4[ch];
          if (hit(apb_req_i.paddr, RELOAD_TIMING_OFFSET)) reload_timing_select[ch] <= wdata4[ch];
          if (hit(apb_req_i.paddr, PWM_FUNC_OFFSET)) pwm_function[ch] <= wdata4[ch];
        end
      end
    end
  end

  // controls to the timer core; mode and toggle masked to timer-driven channels, counter enable passed unmasked
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      channel_ctrl_o <= '0;
    end else if (clk_en_i) begin
      channel_ctrl_o.timer_mode_sync <= output_mode_select & output_source_select;
      channel_ctrl_o.toggle_mode     <= ~output_config & output_source_select;
      channel_ctrl_o.counter_enabled <= counter_enabled_status;
    end
  end

  // ----------------------------------------------------------------
  // reload pending flags: arm sets, trigger completes; arm wins
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      reload_pending_status <= PENDING_RESET;
    end else if (clk_en_i) begin
      reload_pending_status <= (reload_pending_status & ~rewrite_trigger)
                               | ((wr_access && hit(apb_req_i.paddr, RELOAD_ARM_OFFSET)) ? wdata4 : 4'h0);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      reload_done_o <= 4'h0;
    end else if (clk_en_i) begin
      reload_done_o <= rewrite_trigger & reload_pending_status;
    end
  end

  // ----------------------------------------------------------------
  // compare data: staged by software, copied to active at the trigger
  // or at once when reload is disabled
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        compare_stage[ch]         <= '0;
        compare_data_register[ch] <= '0;
      end
    end else if (clk_en_i) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (wr_access && chan_hit(apb_req_i.paddr, COMPARE_STAGE_OFFSET, ch)) begin
          compare_stage[ch] <= apb_req_i.pwdata[CDR_W-1:0];
        end
        if (!reload_enable[ch] || (rewrite_trigger[ch] && reload_pending_status[ch])) begin
          compare_data_register[ch] <= compare_stage[ch];
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      compare_data_o <= '0;
    end else if (clk_en_i) begin
      compare_data_o <= {compare_data_register[3], compare_data_register[2],
                         compare_data_register[1], compare_data_register[0]};
    end
  end

  // ----------------------------------------------------------------
  // apb read mux and response
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    case (apb_req_i.paddr)
      OUTPUT_LEVEL_OFFSET:    next_rdata[3:0] = channel_output_level;
      OUTPUT_SOURCE_OFFSET:   next_rdata[3:0] = output_source_select;
      OUTPUT_POLARITY_OFFSET: next_rdata[3:0] = output_polarity;
      RELOAD_ARM_OFFSET:      next_rdata      = '0;
      RELOAD_STATUS_OFFSET:   next_rdata[3:0] = reload_pending_status;
      OUTPUT_MODE_OFFSET:     next_rdata[3:0] = output_mode_select;
      OUTPUT_CONFIG_OFFSET:   next_rdata[3:0] = output_config;
      RELOAD_ENABLE_OFFSET:   next_rdata[3:0] = reload_enable;
      RELOAD_TIMING_OFFSET:   next_rdata[3:0] = reload_timing_select;
      COUNTER_STATUS_OFFSET:  next_rdata[3:0] = counter_enabled_status;
      COUNTER_START_OFFSET:   next_rdata      = '0;
      COUNTER_STOP_OFFSET:    next_rdata      = '0;
      PWM_FUNC_OFFSET:        next_rdata[3:0] = pwm_function;
      default: begin
        next_err = 1'b1;
        for (int ch = 0; ch < CHANNELS; ch++) begin
          if (chan_hit(apb_req_i.paddr, COMPARE_STAGE_OFFSET, ch)) begin
            next_rdata[CDR_W-1:0] = compare_stage[ch];
            next_err              = 1'b0;
          end
          if (chan_hit(apb_req_i.paddr, COMPARE_ACTIVE_OFFSET, ch)) begin
            next_rdata[CDR_W-1:0] = compare_data_register[ch];
            next_err              = 1'b0;
          end
        end
      end
    endcase
  end

  // one wait state: ready answers in the cycle after penable rises
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o  <= apb_req_i.psel & apb_req_i.penable & ~pready_o;
      prdata_o  <= (rd_access && !pready_o) ? next_rdata : '0;
      pslverr_o <= apb_req_i.psel & apb_req_i.penable & ~pready_o & next_err;
    end
  end

endmodule
`default_nettype wire

// file: dv/timer_output_reload_checker.sv
// checker: port-level assertions for the timer output and reload control block
`timescale 1ns/100ps
`default_nettype none
module timer_output_reload_checker
  import timer_output_reload_pkg::*;
(
  input wire logic                                  clock_i,
  input wire logic                                  rstn_i,
  input wire logic                                  clk_en_i,
  input wire timer_output_reload_pkg::apb_req_t      apb_req_i,
  input wire logic [timer_output_reload_pkg::DATA_W-1:0] prdata_o,
  input wire logic                                  pready_o,
  input wire logic                                  pslverr_o,
  input wire logic [3:0]                            master_start_i,
  input wire logic [3:0]                            channel_output_pin_o,
  input wire timer_output_reload_pkg::channel_ctrl_t channel_ctrl_o,
  input wire logic [3:0]                            reload_done_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic       lvl_wr;
  logic [2:0] lvl_hist;
  // level writes are remembered a few cycles, the pin update lags the access
  assign lvl_wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite
                  && (apb_req_i.paddr == OUTPUT_LEVEL_OFFSET);
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      lvl_hist <= 3'h0;
    end else begin
      lvl_hist <= {lvl_hist[1:0], lvl_wr};
    end
  end

  sequence s_first_access;
    apb_req_i.psel && apb_req_i.penable && !pready_o && clk_en_i;
  endsequence
  sequence s_arm_read;
    s_first_access ##0 (!apb_req_i.pwrite && apb_req_i.paddr == RELOAD_ARM_OFFSET);
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ready_latency: assert property (s_first_access |=> pready_o)
    else $error("pready did not follow the first access cycle");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_arm_reads_zero: assert property (s_arm_read |=> prdata_o == 32'h0)
    else $error("arm register read back nonzero");
  a_done_cause: assert property (|reload_done_o |-> $past(|master_start_i))
    else $error("rewrite done without a master start");
  a_done_once: assert property ((reload_done_o & $past(reload_done_o)) == 4'h0)
    else $error("rewrite done repeated without rearm");
  a_stopped_pin_holds: assert property (
    ((channel_output_pin_o ^ $past(channel_output_pin_o)) & ~channel_ctrl_o.counter_enabled
     & ~$past(channel_ctrl_o.counter_enabled)) != 4'h0 |-> |lvl_hist)
    else $error("stopped channel pin moved without a level write");
  a_mode_guard: assert property (
    ((channel_ctrl_o.timer_mode_sync ^ $past(channel_ctrl_o.timer_mode_sync))
     & channel_ctrl_o.counter_enabled & $past(channel_ctrl_o.counter_enabled)) == 4'h0)
    else $error("output mode changed on a running channel");
endmodule

bind timer_output_reload_ctrl timer_output_reload_checker u_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .apb_req_i(apb_req_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .master_start_i(master_start_i), .channel_output_pin_o(channel_output_pin_o),
  .channel_ctrl_o(channel_ctrl_o), .reload_done_o(reload_done_o)
);
`default_nettype wire

// file: dv/test_timer_output_reload_ctrl.sv
// testbench: register-level tests of the timer output and reload control block
`timescale 1ns/100ps
`default_nettype none
module test_timer_output_reload_ctrl;
  import timer_output_reload_pkg::*;

  logic         clock_i = 1'b0;
  logic         rstn_i = 1'b0;
  logic         clk_en = 1'b1;
  apb_req_t     req = '0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [3:0]   start_in = 4'h0;
  logic [3:0]   mstart = 4'h0;
  logic [3:0]   tlevel = 4'h0;
  logic [3:0]   pin;
  channel_ctrl_t ctrl;
  logic [3:0]   done;
  logic [63:0]  cmp;
  logic [3:0]   done_seen = 4'h0;
  logic [31:0]  rd;
  logic         er;
  int           n_fail = 0;
  int           check_count = 0;

  timer_output_reload_ctrl dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .clk_en_i(clk_en), .apb_req_i(req),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .start_input_i(start_in), .master_start_i(mstart), .timer_level_i(tlevel),
    .channel_output_pin_o(pin), .channel_ctrl_o(ctrl), .reload_done_o(done), .compare_data_o(cmp)
  );

  // ----------------------------------------------------------------
  // clock, done monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // done is a one-cycle pulse, so keep a sticky copy
  always @(posedge clock_i) done_seen <= done_seen | done;
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // request held until pready is sampled high, released at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i) req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock_i) req.penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse_master(input logic [3:0] m);
    @(posedge clock_i) mstart <= m;
    @(posedge clock_i) mstart <= 4'h0;
    repeat (3) @(posedge clock_i);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    rdchk(OUTPUT_SOURCE_OFFSET, 32'h0);
    rdchk(OUTPUT_CONFIG_OFFSET, 32'h0);
    rdchk(RELOAD_ENABLE_OFFSET, 32'h0);
    rdchk(RELOAD_ARM_OFFSET, 32'h0);
    rdchk(RELOAD_STATUS_OFFSET, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, er}, 32'h1);
    // software owns all pins, then only the low two
    wr(OUTPUT_LEVEL_OFFSET, 32'h5);
    rdchk(OUTPUT_LEVEL_OFFSET, 32'h5);
    chk({28'h0, pin}, 32'h5);
    wr(OUTPUT_SOURCE_OFFSET, 32'hC);
    rdchk(OUTPUT_SOURCE_OFFSET, 32'hC);
    wr(OUTPUT_LEVEL_OFFSET, 32'hA);
    rdchk(OUTPUT_LEVEL_OFFSET, 32'h6);
    // timer drives ch2/ch3 with inverted polarity
    tlevel <= 4'h3;
    wr(OUTPUT_POLARITY_OFFSET, 32'hF);
    wr(COUNTER_START_OFFSET, 32'hC);
    repeat (3) @(posedge clock_i);
    rdchk(COUNTER_STATUS_OFFSET, 32'hC);
    chk({28'h0, pin}, 32'hE);
    rdchk(OUTPUT_LEVEL_OFFSET, 32'hE);
    wr(OUTPUT_POLARITY_OFFSET, 32'h0);
    repeat (3) @(posedge clock_i);
    chk({28'h0, pin}, 32'h2);
    // guarded registers accept only stopped channels
    wr(OUTPUT_MODE_OFFSET, 32'hF);
    rdchk(OUTPUT_MODE_OFFSET, 32'h3);
    chk({28'h0, ctrl.timer_mode_sync}, 32'h0);
    wr(RELOAD_ENABLE_OFFSET, 32'hF);
    rdchk(RELOAD_ENABLE_OFFSET, 32'h3);
    wr(RELOAD_TIMING_OFFSET, 32'hF);
    rdchk(RELOAD_TIMING_OFFSET, 32'h3);
    @(posedge clock_i) start_in <= 4'h1;
    @(posedge clock_i) start_in <= 4'h0;
    rdchk(COUNTER_STATUS_OFFSET, 32'hD);
    // stopping freezes the timer-driven pins
    wr(COUNTER_STOP_OFFSET, 32'hD);
    tlevel <= 4'hF;
    repeat (3) @(posedge clock_i);
    rdchk(COUNTER_STATUS_OFFSET, 32'h0);
    chk({28'h0, pin}, 32'h2);
    wr(OUTPUT_MODE_OFFSET, 32'h0);
    wr(RELOAD_TIMING_OFFSET, 32'h0);
    wr(RELOAD_ENABLE_OFFSET, 32'h1);
    rdchk(RELOAD_ENABLE_OFFSET, 32'h1);
    chk({28'h0, ctrl.timer_mode_sync}, 32'h0);
    // staged compare data waits for the trigger only where reload is on
    wr(COMPARE_STAGE_OFFSET, 32'hBEEF);
    wr(COMPARE_STAGE_OFFSET + 8'h04, 32'h1234);
    repeat (3) @(posedge clock_i);
    chk({16'h0, cmp[15:0]}, 32'h0);
    chk({16'h0, cmp[31:16]}, 32'h1234);
    wr(RELOAD_ARM_OFFSET, 32'h3);
    rdchk(RELOAD_STATUS_OFFSET, 32'h3);
    rdchk(RELOAD_ARM_OFFSET, 32'h0);
    pulse_master(4'h3);
    rdchk(RELOAD_STATUS_OFFSET, 32'h2);
    chk({16'h0, cmp[15:0]}, 32'hBEEF);
    chk({28'h0, done_seen}, 32'h1);
    // without rearm a second trigger changes nothing
    wr(COMPARE_STAGE_OFFSET, 32'h5555);
    pulse_master(4'h1);
    chk({16'h0, cmp[15:0]}, 32'hBEEF);
    // a trigger while the clock enable is low must be ignored
    wr(RELOAD_ARM_OFFSET, 32'h1);
    @(posedge clock_i) begin
      clk_en <= 1'b0;
      mstart <= 4'h1;
    end
    @(posedge clock_i) mstart <= 4'h0;
    repeat (2) @(posedge clock_i);
    clk_en <= 1'b1;
    rdchk(RELOAD_STATUS_OFFSET, 32'h3);
    complete_run();
  end
endmodule
`default_nettype wire
